// *** core/uei_consts.vh ***
`ifndef UEI_CONSTS_VH
`define UEI_CONSTS_VH
// Notes on behaviour
// RULE1: Each of the five sources has a rising-edge enable bit (detach 0, supply 1, session valid 2, session end 3, id grounded 4) that resets to one.
// RULE2: Each source also has a falling-edge enable bit at the same position that resets to one.
// RULE3: The rising enable byte reads at 0Dh to 0Fh and is loaded at 0Dh, set at 0Eh and cleared at 0Fh.
// RULE4: The falling enable byte reads at 10h to 12h and is loaded at 10h, set at 11h and cleared at 12h.
// RULE5: Detach events count only while the transceiver is in host role.
// RULE6: Bits 7 to 5 of the enable, status and sticky bytes read as zero and ignore writes.
// RULE7: The status byte at 13h shows the live source levels at the enable bit positions.
// RULE8: Status bit 1 reads zero while both supply edge enables are set.
// RULE9: Status bit 3 reads zero while both session end edge enables are set.
// RULE10: Status bit 2 always shows the session valid level whatever its enables hold.
// RULE11: Status is zero just after reset and whenever the sampled sources are low, and a read returns the levels sampled at that read.
// RULE12: The sticky byte at 14h sets a bit when an enabled edge occurs on its source.
// RULE13: Reading the sticky byte returns it and then clears it, and it cannot be written.
// RULE14: The debug byte at 15h shows the two line level bits in bits 1 to 0, zero above, zero at reset.
// RULE15: A set address ORs the written bits in and a clear address clears the bits written as one.
// RULE16: An event is a change of a sampled source, in an enabled direction, seen against its previous sample.

// ============================================================
// Register addresses
`define UEI_ADDR_RISE       6'h0D
`define UEI_ADDR_RISE_SET   6'h0E
`define UEI_ADDR_RISE_CLR   6'h0F
`define UEI_ADDR_FALL       6'h10
`define UEI_ADDR_FALL_SET   6'h11
`define UEI_ADDR_FALL_CLR   6'h12
`define UEI_ADDR_STATUS     6'h13
`define UEI_ADDR_STICKY     6'h14
`define UEI_ADDR_DEBUG      6'h15

// ============================================================
// Field positions and widths
`define UEI_SRC_W           5
`define UEI_BIT_DETACH      0
`define UEI_BIT_SUPPLY      1
`define UEI_BIT_SESS_VALID  2
`define UEI_BIT_SESS_END    3
`define UEI_BIT_ID_GND      4
`define UEI_LINE_W          2

// ============================================================
// Reset values
`define UEI_MASK_RESET      5'h1F
`define UEI_STATUS_RESET    5'h00
`define UEI_STICKY_RESET    5'h00
`define UEI_DEBUG_RESET     2'h0

// ============================================================
// Command byte codes, top two bits
`define UEI_CMD_WRITE       2'h2
`define UEI_CMD_READ        2'h3

// ============================================================
// Write operation selectors
`define UEI_OP_LOAD         2'h0
`define UEI_OP_SET          2'h1
`define UEI_OP_CLEAR        2'h2

`endif

// *** core/uei_regs.v ***
`timescale 1ns/1ps
`include "uei_consts.vh"
module uei_regs (
    input  wire       ref_clk,
    input  wire       rstn,
    input  wire       ulpi_clk,
    input  wire [7:0] ulpi_data_in,
    output reg  [7:0] ulpi_data_out,
    output reg        ulpi_data_oe,
    output reg        ulpi_dir,
    output reg        ulpi_nxt,
    input  wire       ulpi_stp,
    input  wire       host_role,
    input  wire       downstream_detach_flag,
    input  wire       supply_valid_flag,
    input  wire       session_valid_flag,
    input  wire       session_end_flag,
    input  wire       id_grounded_flag,
    input  wire [1:0] line_level
);

    // ============================================================
    // States of the register access sequence
    localparam [2:0] ST_IDLE   = 3'h0;
    localparam [2:0] ST_W_ACK  = 3'h1;
    localparam [2:0] ST_W_DATA = 3'h2;
    localparam [2:0] ST_W_STP  = 3'h3;
    localparam [2:0] ST_R_ACK  = 3'h4;
    localparam [2:0] ST_R_TURN = 3'h5;
    localparam [2:0] ST_R_DATA = 3'h6;

    // ============================================================
    // Synchronisers
    wire                  clk_s;
    wire                  stp_s;
    wire [7:0]            data_s;
    wire [`UEI_SRC_W-1:0] src_s;
    wire                  host_s;
    wire [`UEI_LINE_W-1:0] line_s;

    uei_sync #(
        .WIDTH (10)
    ) u_link_sync (
        .clk      (ref_clk),
        .rstn     (rstn),
        .async_in ({ulpi_clk, ulpi_stp, ulpi_data_in}),
        .sync_out ({clk_s, stp_s, data_s})
    );

    // Sources, role and line levels come from analog comparators
    uei_sync #(
        .WIDTH (`UEI_SRC_W + 1 + `UEI_LINE_W)
    ) u_src_sync (
        .clk      (ref_clk),
        .rstn     (rstn),
        .async_in ({id_grounded_flag, session_end_flag, session_valid_flag,
                    supply_valid_flag, downstream_detach_flag, host_role, line_level}),
        .sync_out ({src_s, host_s, line_s})
    );

    // ============================================================
    // Functions
    function in_range;
        input [5:0] addr;
        input [5:0] base;
        begin
            in_range = (addr >= base) && (addr <= base + 6'h02);
        end
    endfunction

    function [`UEI_SRC_W-1:0] mask_next;
        input [`UEI_SRC_W-1:0] old;
        input [`UEI_SRC_W-1:0] val;
        input [1:0]            op;
        begin
            case (op)
                `UEI_OP_LOAD:  mask_next = val;
                `UEI_OP_SET:   mask_next = old | val;
                `UEI_OP_CLEAR: mask_next = old & ~val;
                default:       mask_next = old;
            endcase
        end
    endfunction

    // ============================================================
    // Link edge detection
    reg        clk_prev;
    reg [7:0]  data_prev;
    wire       link_edge = clk_s & ~clk_prev;

    // ============================================================
    // Register state
    reg [`UEI_SRC_W-1:0] rise_mask;
    reg [`UEI_SRC_W-1:0] fall_mask;
    reg [`UEI_SRC_W-1:0] src_prev;
    reg [`UEI_SRC_W-1:0] sticky;
    reg [2:0]            state;
    reg [5:0]            cmd_addr;
    reg [7:0]            wr_data;

    // ============================================================
    // Event detection
    wire [`UEI_SRC_W-1:0] rise_ev = src_s & ~src_prev & rise_mask;    // see RULE1 see RULE16
    wire [`UEI_SRC_W-1:0] fall_ev = ~src_s & src_prev & fall_mask;    // see RULE2 see RULE16
    wire [`UEI_SRC_W-1:0] ev_raw  = rise_ev | fall_ev;
    wire [`UEI_SRC_W-1:0] events;

    assign events = {ev_raw[`UEI_SRC_W-1:1], ev_raw[`UEI_BIT_DETACH] & host_s};  // see RULE5

    // ============================================================
    // Read view
    reg [`UEI_SRC_W-1:0] status_view;
    reg [7:0]            rd_byte;

    always @* begin
        status_view = src_s;    // see RULE7 see RULE10 see RULE11
        if (rise_mask[`UEI_BIT_SUPPLY] && fall_mask[`UEI_BIT_SUPPLY]) begin
            status_view[`UEI_BIT_SUPPLY] = 1'b0;    // see RULE8
        end
        if (rise_mask[`UEI_BIT_SESS_END] && fall_mask[`UEI_BIT_SESS_END]) begin
            status_view[`UEI_BIT_SESS_END] = 1'b0;  // see RULE9
        end
    end

    always @* begin
        rd_byte = 8'h00;    // see RULE6
        if (in_range(cmd_addr, `UEI_ADDR_RISE)) begin
            rd_byte = {3'h0, rise_mask};    // see RULE3
        end else if (in_range(cmd_addr, `UEI_ADDR_FALL)) begin
            rd_byte = {3'h0, fall_mask};    // see RULE4
        end else if (cmd_addr == `UEI_ADDR_STATUS) begin
            rd_byte = {3'h0, status_view};
        end else if (cmd_addr == `UEI_ADDR_STICKY) begin
            rd_byte = {3'h0, sticky};
        end else if (cmd_addr == `UEI_ADDR_DEBUG) begin
            rd_byte = {6'h00, line_s};      // see RULE14
        end
    end

    // ============================================================
    // Write and read-clear strobes
    wire wr_commit  = link_edge && (state == ST_W_STP) && stp_s;
    wire rd_sticky  = link_edge && (state == ST_R_TURN) && (cmd_addr == `UEI_ADDR_STICKY);
    // Offset from the base selects load, set or clear
    wire [5:0] rise_off = cmd_addr - `UEI_ADDR_RISE;
    wire [5:0] fall_off = cmd_addr - `UEI_ADDR_FALL;
    wire [1:0] rise_op  = rise_off[1:0];
    wire [1:0] fall_op  = fall_off[1:0];

    // Masks
    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            rise_mask <= `UEI_MASK_RESET;   // see RULE1
            fall_mask <= `UEI_MASK_RESET;   // see RULE2
        end else if (wr_commit) begin
            if (in_range(cmd_addr, `UEI_ADDR_RISE)) begin
                rise_mask <= mask_next(rise_mask, wr_data[`UEI_SRC_W-1:0], rise_op); // see RULE3 see RULE15
            end
            if (in_range(cmd_addr, `UEI_ADDR_FALL)) begin
                fall_mask <= mask_next(fall_mask, wr_data[`UEI_SRC_W-1:0], fall_op); // see RULE4 see RULE15
            end
        end
    end

    // Sticky flags; a new event wins over a clearing read in the same cycle
    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            src_prev <= `UEI_STATUS_RESET;
            sticky   <= `UEI_STICKY_RESET;
        end else begin
            src_prev <= src_s;
            sticky   <= (sticky & ~{`UEI_SRC_W{rd_sticky}}) | events;    // see RULE12 see RULE13
        end
    end

    // ============================================================
    // Register access sequence, stepped on each sampled link clock rise
    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            clk_prev      <= 1'b0;
            data_prev     <= 8'h00;
            state         <= ST_IDLE;
            cmd_addr      <= 6'h00;
            wr_data       <= 8'h00;
            ulpi_data_out <= 8'h00;
            ulpi_data_oe  <= 1'b0;
            ulpi_dir      <= 1'b0;
            ulpi_nxt      <= 1'b0;
        end else begin
            clk_prev  <= clk_s;
            // Data seen one sample before the edge, clear of the link's hold window
            data_prev <= data_s;
            if (link_edge) begin
                case (state)
                    ST_IDLE: begin
                        if (data_prev[7:6] == `UEI_CMD_WRITE) begin
                            cmd_addr <= data_prev[5:0];
                            ulpi_nxt <= 1'b1;
                            state    <= ST_W_ACK;
                        end else if (data_prev[7:6] == `UEI_CMD_READ) begin
                            cmd_addr <= data_prev[5:0];
                            ulpi_nxt <= 1'b1;
                            state    <= ST_R_ACK;
                        end
                    end
                    ST_W_ACK: begin
                        state <= ST_W_DATA;
                    end
                    ST_W_DATA: begin
                        wr_data  <= data_prev;
                        ulpi_nxt <= 1'b0;
                        state    <= ST_W_STP;
                    end
                    ST_W_STP: begin
                        // Without a stop the write is dropped; the sequence never hangs
                        state <= ST_IDLE;
                    end
                    ST_R_ACK: begin
                        ulpi_nxt <= 1'b0;
                        ulpi_dir <= 1'b1;
                        state    <= ST_R_TURN;
                    end
                    ST_R_TURN: begin
                        ulpi_data_out <= rd_byte;   // see RULE11 see RULE13
                        ulpi_data_oe  <= 1'b1;
                        state         <= ST_R_DATA;
                    end
                    ST_R_DATA: begin
                        ulpi_data_out <= 8'h00;
                        ulpi_data_oe  <= 1'b0;
                        ulpi_dir      <= 1'b0;
                        state         <= ST_IDLE;
                    end
                    default: begin
                        ulpi_nxt <= 1'b0;
                        state    <= ST_IDLE;
                    end
                endcase
            end
        end
    end

endmodule

// *** core/uei_sync.v ***
`timescale 1ns/1ps
module uei_sync #(
    parameter WIDTH = 1
) (
    input  wire             clk,
    input  wire             rstn,
    input  wire [WIDTH-1:0] async_in,
    output reg  [WIDTH-1:0] sync_out
);
    reg [WIDTH-1:0] stage1;

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            stage1   <= {WIDTH{1'b0}};
            sync_out <= {WIDTH{1'b0}};
        end else begin
            stage1   <= async_in;
            sync_out <= stage1;
        end
    end
endmodule

// *** test/uei_link_model.sv ***
`timescale 1ns/1ps
module uei_link_model (
    input  wire       ref_clk,
    input  wire [7:0] ulpi_data_out,
    output reg        ulpi_clk,
    output reg  [7:0] ulpi_data_in,
    output reg        ulpi_stp
);
    initial begin
        ulpi_clk = 1'b0;
        ulpi_data_in = 8'h00;
        ulpi_stp = 1'b0;
    end
    // ============================================================
    // One link edge; clock stands still between frames
    task edge_step(input [7:0] d, input s, input drive, output [7:0] seen);
        begin
            @(posedge ref_clk);
            // Released bus shows the inverse, never a stale copy
            ulpi_data_in <= drive ? d : ~ulpi_data_in;
            ulpi_stp <= s;
            repeat (4) @(posedge ref_clk);
            ulpi_clk <= 1'b1;
            repeat (4) @(posedge ref_clk);
            ulpi_clk <= 1'b0;
            repeat (2) @(posedge ref_clk);
            seen = ulpi_data_out;
        end
    endtask
    // ============================================================
    // Whole access: command, turn or data, stop
    task access(input rd, input [5:0] addr, input [7:0] wd, output [7:0] rdat);
        reg [7:0] tmp;
        begin
            edge_step({1'b1, rd, addr}, 1'b0, 1'b1, tmp);
            edge_step(8'h00, 1'b0, !rd, tmp);
            edge_step(wd, 1'b0, !rd, rdat);
            edge_step(8'h00, !rd, !rd, tmp);
        end
    endtask
endmodule

// *** test/uei_regs_chk.sv ***
`timescale 1ns/1ps
module uei_regs_chk (
    input wire       ref_clk,
    input wire       rstn,
    input wire       ulpi_clk,
    input wire [7:0] ulpi_data_in,
    input wire [7:0] ulpi_data_out,
    input wire       ulpi_data_oe,
    input wire       ulpi_dir,
    input wire       ulpi_nxt,
    input wire       ulpi_stp
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    a_oe_needs_dir: assert property (ulpi_data_oe |-> ulpi_dir)
        else $error("data driven with bus not turned");
    a_idle_bus_zero: assert property (!ulpi_dir |-> ulpi_data_out == 8'h00)
        else $error("read byte outside read phase");
    a_nxt_dir_excl: assert property (!(ulpi_nxt && ulpi_dir))
        else $error("accept and turn together");
    a_quiet_outputs: assert property ((!ulpi_clk)[*6] |=>
        $stable(ulpi_dir) && $stable(ulpi_nxt) && $stable(ulpi_data_oe) && $stable(ulpi_data_out))
        else $error("outputs moved without a link edge");
    a_dir_after_nxt: assert property ($rose(ulpi_dir) |-> $fell(ulpi_nxt))
        else $error("turn without prior accept");
    a_oe_after_dir: assert property ($rose(ulpi_data_oe) |-> $past(ulpi_dir))
        else $error("data driven before turn");
    a_oe_holds: assert property ($rose(ulpi_data_oe) |-> ulpi_data_oe[*6])
        else $error("read byte too short");
    a_nxt_holds: assert property ($rose(ulpi_nxt) |-> ulpi_nxt[*6])
        else $error("accept too short");
    a_cmd_answer: assert property ($rose(ulpi_clk) && !ulpi_nxt && !ulpi_dir &&
        ulpi_data_in[7] && !ulpi_stp |-> ##[1:5] ulpi_nxt)
        else $error("command not accepted");
endmodule

// *** test/uei_regs_tb.sv ***
`timescale 1ns/1ps
module uei_regs_tb;
    reg        ref_clk;
    reg        rstn;
    reg        host_role;
    reg  [4:0] src;
    reg  [1:0] line_level;
    reg  [7:0] rdat;
    wire       ulpi_clk;
    wire       ulpi_stp;
    wire       ulpi_data_oe;
    wire       ulpi_dir;
    wire       ulpi_nxt;
    wire [7:0] ulpi_data_in;
    wire [7:0] ulpi_data_out;
    integer    n_fail;
    integer    comparisons;
    integer    cycles;

    uei_regs DUT (.ref_clk(ref_clk), .rstn(rstn), .ulpi_clk(ulpi_clk),
        .ulpi_data_in(ulpi_data_in), .ulpi_data_out(ulpi_data_out),
        .ulpi_data_oe(ulpi_data_oe), .ulpi_dir(ulpi_dir), .ulpi_nxt(ulpi_nxt),
        .ulpi_stp(ulpi_stp), .host_role(host_role), .downstream_detach_flag(src[0]),
        .supply_valid_flag(src[1]), .session_valid_flag(src[2]),
        .session_end_flag(src[3]), .id_grounded_flag(src[4]), .line_level(line_level));
    uei_link_model u_link (.ref_clk(ref_clk), .ulpi_data_out(ulpi_data_out),
        .ulpi_clk(ulpi_clk), .ulpi_data_in(ulpi_data_in), .ulpi_stp(ulpi_stp));

    initial ref_clk = 1'b0;
    always #25 ref_clk = ~ref_clk;

    task give_verdict;
        begin
            $display("Mismatches %0d, comparisons %0d", n_fail, comparisons);
            if (n_fail == 0 && comparisons > 0)
                $display("Test passed");
            else
                $display("Test failed");
            $finish;
        end
    endtask

    task chk(input [7:0] seen, input [7:0] exp);
        begin
            comparisons = comparisons + 1;
            if (seen !== exp) begin
                n_fail = n_fail + 1;
                $display("Error at %0t: read %h expected %h", $time, seen, exp);
            end
        end
    endtask

    task rd(input [5:0] a, input [7:0] exp);
        begin
            u_link.access(1'b1, a, 8'h00, rdat);
            chk(rdat, exp);
        end
    endtask

    task wr(input [5:0] a, input [7:0] d);
        u_link.access(1'b0, a, d, rdat);
    endtask

    // ============================================================
    // Hang guard, about four and a half times the expected run
    always @(posedge ref_clk) begin
        cycles = cycles + 1;
        if (cycles == 6000) begin
            n_fail = n_fail + 1;
            give_verdict;
        end
    end

    // ============================================================
    // Main sequence
    initial begin
        rstn = 1'b0;
        host_role = 1'b0;
        src = 5'h00;
        line_level = 2'h0;
        n_fail = 0;
        comparisons = 0;
        cycles = 0;
        repeat (12) @(posedge ref_clk);
        rstn <= 1'b1;
        repeat (3) @(posedge ref_clk);
        rd(6'h0D, 8'h1F);
        rd(6'h10, 8'h1F);
        rd(6'h13, 8'h00);
        rd(6'h14, 8'h00);
        line_level <= 2'h2;
        rd(6'h15, 8'h02);
        rd(6'h20, 8'h00);
        wr(6'h0D, 8'hFF);
        rd(6'h0E, 8'h1F);
        wr(6'h0F, 8'h02);
        rd(6'h0D, 8'h1D);
        wr(6'h0E, 8'h02);
        rd(6'h0F, 8'h1F);
        wr(6'h10, 8'h00);
        wr(6'h11, 8'h0A);
        wr(6'h12, 8'h08);
        rd(6'h11, 8'h02);
        src <= 5'h1F;
        rd(6'h13, 8'h1D);
        rd(6'h14, 8'h1E);
        rd(6'h14, 8'h00);
        wr(6'h11, 8'h08);
        rd(6'h13, 8'h15);
        wr(6'h14, 8'hFF);
        rd(6'h14, 8'h00);
        host_role <= 1'b1;
        src <= 5'h1E;
        rd(6'h14, 8'h00);
        src <= 5'h1F;
        rd(6'h14, 8'h01);
        src <= 5'h13;
        rd(6'h14, 8'h08);
        rd(6'h13, 8'h11);
        wr(6'h11, 8'h04);
        src <= 5'h17;
        rd(6'h13, 8'h15);
        give_verdict;
    end
endmodule

bind uei_regs uei_regs_chk u_chk (.ref_clk(ref_clk), .rstn(rstn), .ulpi_clk(ulpi_clk),
    .ulpi_data_in(ulpi_data_in), .ulpi_data_out(ulpi_data_out), .ulpi_data_oe(ulpi_data_oe),
    .ulpi_dir(ulpi_dir), .ulpi_nxt(ulpi_nxt), .ulpi_stp(ulpi_stp));
